/* ioc_pkg.sv */
// Package: timing constants and state encoding for the I/O cycle control logic
package ioc_pkg;

    // ------------------------------------------------------------------
    // Timing and counts
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned READ_WAIT_STATES  = 2;
    localparam int unsigned WRITE_DELAY_CLKS  = 1;
    localparam int unsigned WRITE_WAIT_STATES = 2;
    localparam int unsigned RECOVERY_NS       = 30;
    localparam int unsigned RECOVERY_CLKS     = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W             = 4;
    localparam logic [3:0]  CNT_ZERO          = 4'h0;

    // ------------------------------------------------------------------
    // Cycle states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IOC_IDLE  = 3'b000,
        IOC_HOLD  = 3'b001,
        IOC_RSTB  = 3'b010,
        IOC_WDLY  = 3'b011,
        IOC_WSTB  = 3'b100,
        IOC_RECOVERY_HOLD = 3'b101
    } ioc_state_t;

endpackage : ioc_pkg

/* ioc_post_if.sv */
// Interface: posted-write latch request and status between cycle control and latch
`timescale 1ns/1ps
interface ioc_post_if #(
    parameter int unsigned AW = 16,
    parameter int unsigned DW = 32
);
    logic          load;
    logic [AW-1:0] addr_in;
    logic [DW-1:0] data_in;
    logic          full;
    logic          release_q;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;

    modport ctrl  (output load, output addr_in, output data_in, output release_q,
                   input full, input addr, input data);
    modport latch (input load, input addr_in, input data_in, input release_q,
                   output full, output addr, output data);
endinterface : ioc_post_if

/* ioc_post_latch.sv */
// Posted-write address and data latch
`timescale 1ns/1ps
module ioc_post_latch #(
    parameter int unsigned AW = 16,
    parameter int unsigned DW = 32
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    ioc_post_if.latch pw
);

    typedef struct packed {
        logic          full;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } ioc_latch_t;

    ioc_latch_t s_q;
    ioc_latch_t s_d;

    // ------------------------------------------------------------------
    // Capture on load, free on release
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (pw.release_q) begin
            s_d.full = 1'b0;
        end
        if (pw.load) begin
            s_d.full = 1'b1;
            s_d.addr = pw.addr_in;
            s_d.data = pw.data_in;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pw.full = s_q.full;
    assign pw.addr = s_q.addr;
    assign pw.data = s_q.data;

    property p_latch_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        (s_q.full && !pw.release_q && !pw.load) |=> (s_q.addr == $past(s_q.addr)) && s_q.full;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Posted latch lost its contents");

endmodule // ioc_post_latch

/* ioc_cycle_ctrl.sv */
// Top: processor I/O bus cycle to peripheral strobe control
`timescale 1ns/1ps
// Operation
// - Pending I/O cycle decoded from address strobe and two status lines, mem_io_sel_i and data_ctrl_sel_i.
// - Read strobe asserted in T2 only when pending and recovery inactive.
// - Recovery active holds off the read strobe until released.
// - Two wait states hold read strobe for minimum active time.
// - Write strobe follows chip select by one or two clocks.
// - Write data stays valid through the rising edge of write strobe.
// - Posted mode latches address and data, ready given in first T2.
// - Posted peripheral write runs from latches while processor continues.
// - Recovery held after each access until read data floats.
// - Transceiver direction is latched write/read, high for writes.
module ioc_cycle_ctrl #(
    parameter int unsigned AW          = 16,
    parameter int unsigned DW          = 32,
    parameter int unsigned WRITE_DELAY = ioc_pkg::WRITE_DELAY_CLKS
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          address_strobe_n_i,
    input  wire logic          mem_io_sel_i,
    input  wire logic          write_read_sel_i,
    input  wire logic          data_ctrl_sel_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic          posted_mode_i,
    output logic               io_cycle_pending_o,
    output logic               io_read_strobe_n_o,
    output logic               io_write_strobe_n_o,
    output logic               chip_select_n_o,
    output logic               recovery_hold_o,
    output logic               transceiver_direction_o,
    output logic               ready_n_o,
    output logic [AW-1:0]      io_addr_o,
    output logic [DW-1:0]      io_wdata_o,
    output logic               io_wdata_oe_o
);

    if (WRITE_DELAY < 1 || WRITE_DELAY > 2) begin : g_bad_delay
        $error("WRITE_DELAY must be 1 or 2");
    end
    if (AW < 1 || DW < 8) begin : g_bad_width
        $error("Bus widths too small");
    end

    localparam int unsigned CNT_W = ioc_pkg::CNT_W;

    typedef struct packed {
        ioc_pkg::ioc_state_t        st;
        logic [ioc_pkg::CNT_W-1:0]  cnt;
        logic [ioc_pkg::CNT_W-1:0]  rcnt;
        logic                       pend;
        logic                       wr;
        logic                       posted;
        logic                       rd_n;
        logic                       wr_n;
        logic                       cs_n;
        logic                       dir;
        logic                       rdy_n;
        logic                       oe;
        logic                       wait_post;
        logic [AW-1:0]              addr;
        logic [DW-1:0]              data;
    } ioc_ctrl_t;

    ioc_ctrl_t s_q;
    ioc_ctrl_t s_d;

    ioc_post_if #(.AW(AW), .DW(DW)) pw ();

    ioc_post_latch #(.AW(AW), .DW(DW)) u_latch (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .pw      (pw)
    );

    // ------------------------------------------------------------------
    // Cycle decode
    // ------------------------------------------------------------------
    logic io_start;
    logic recovery_hold_busy;
    assign io_start   = !address_strobe_n_i && !mem_io_sel_i && data_ctrl_sel_i;
    assign recovery_hold_busy = (s_q.rcnt != ioc_pkg::CNT_ZERO);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.rdy_n      = 1'b1;
        pw.load        = 1'b0;
        pw.release_q   = 1'b0;
        pw.addr_in     = addr_i;
        pw.data_in     = wdata_i;
        if (recovery_hold_busy) begin
            s_d.rcnt = s_q.rcnt - 4'h1;
        end
        case (s_q.st)
            ioc_pkg::IOC_IDLE: begin
                if (io_start) begin
                    s_d.pend = 1'b1;
                    s_d.wr   = write_read_sel_i;
                    s_d.dir  = write_read_sel_i;
                    s_d.addr = addr_i;
                    s_d.posted = posted_mode_i && write_read_sel_i;
                    s_d.st   = ioc_pkg::IOC_HOLD;
                end
            end
            ioc_pkg::IOC_HOLD: begin
                // T2: data from the processor is valid now
                if (s_q.wr) begin
                    s_d.data = wdata_i;
                end
                if (s_q.posted && !pw.full) begin
                    pw.load    = 1'b1;
                    s_d.rdy_n  = 1'b0;
                    s_d.wait_post = 1'b1;
                    s_d.pend   = 1'b0;
                    s_d.st     = ioc_pkg::IOC_RECOVERY_HOLD;
                end else if (!s_q.posted && !recovery_hold_busy) begin
                    s_d.cs_n = 1'b0;
                    s_d.oe   = s_q.wr;
                    if (s_q.wr) begin
                        s_d.cnt = CNT_W'(WRITE_DELAY - 1);
                        s_d.st  = ioc_pkg::IOC_WDLY;
                    end else begin
                        s_d.rd_n = 1'b0;
                        s_d.cnt  = CNT_W'(ioc_pkg::READ_WAIT_STATES);
                        s_d.st   = ioc_pkg::IOC_RSTB;
                    end
                end
            end
            ioc_pkg::IOC_RSTB: begin
                if (s_q.cnt != ioc_pkg::CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    s_d.rd_n  = 1'b1;
                    s_d.cs_n  = 1'b1;
                    s_d.pend  = 1'b0;
                    s_d.rdy_n = 1'b0;
                    s_d.rcnt  = CNT_W'(ioc_pkg::RECOVERY_CLKS);
                    s_d.st    = ioc_pkg::IOC_IDLE;
                end
            end
            ioc_pkg::IOC_WDLY: begin
                if (s_q.cnt != ioc_pkg::CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    s_d.wr_n = 1'b0;
                    s_d.cnt  = CNT_W'(ioc_pkg::WRITE_WAIT_STATES);
                    s_d.st   = ioc_pkg::IOC_WSTB;
                end
            end
            ioc_pkg::IOC_WSTB: begin
                if (s_q.cnt != ioc_pkg::CNT_ZERO) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    // Data and chip select stay one clock past the strobe edge
                    s_d.wr_n = 1'b1;
                    s_d.pend = 1'b0;
                    s_d.rcnt = CNT_W'(ioc_pkg::RECOVERY_CLKS);
                    if (s_q.wait_post) begin
                        pw.release_q  = 1'b1;
                        s_d.wait_post = 1'b0;
                    end else begin
                        s_d.rdy_n = 1'b0;
                    end
                    s_d.st = ioc_pkg::IOC_RECOVERY_HOLD;
                end
            end
            ioc_pkg::IOC_RECOVERY_HOLD: begin
                // Drop drivers after the strobe edge; run a waiting posted write
                s_d.cs_n = 1'b1;
                s_d.oe   = 1'b0;
                if (s_q.wait_post && !recovery_hold_busy && s_q.wr_n) begin
                    s_d.addr = pw.addr;
                    s_d.data = pw.data;
                    s_d.dir  = 1'b1;
                    s_d.cs_n = 1'b0;
                    s_d.oe   = 1'b1;
                    s_d.cnt  = CNT_W'(WRITE_DELAY - 1);
                    s_d.st   = ioc_pkg::IOC_WDLY;
                end else if (!s_q.wait_post) begin
                    s_d.st = ioc_pkg::IOC_IDLE;
                end else if (io_start) begin
                    // Processor runs on; a new I/O cycle seen here is not captured
                    s_d.st = ioc_pkg::IOC_RECOVERY_HOLD;
                end
            end
            default: begin
                s_d.st = ioc_pkg::IOC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q       <= '0;
            s_q.st    <= ioc_pkg::IOC_IDLE;
            s_q.rd_n  <= 1'b1;
            s_q.wr_n  <= 1'b1;
            s_q.cs_n  <= 1'b1;
            s_q.rdy_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign io_cycle_pending_o      = s_q.pend;
    assign io_read_strobe_n_o      = s_q.rd_n;
    assign io_write_strobe_n_o     = s_q.wr_n;
    assign chip_select_n_o         = s_q.cs_n;
    assign recovery_hold_o         = recovery_hold_busy;
    assign transceiver_direction_o = s_q.dir;
    assign ready_n_o               = s_q.rdy_n;
    assign io_addr_o               = s_q.addr;
    assign io_wdata_o              = s_q.data;
    assign io_wdata_oe_o           = s_q.oe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_rd_no_recovery_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(io_read_strobe_n_o) |-> $past(!recovery_hold_busy) && io_cycle_pending_o;
    endproperty
    a_rd_no_recovery_hold: assert property (p_rd_no_recovery_hold) else $error("Read strobe during recovery");

    property p_rd_width;
        @(posedge clk_i) disable iff (!rst_b_i)
        $fell(io_read_strobe_n_o) |-> !io_read_strobe_n_o [*3] ##1 io_read_strobe_n_o;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("Read strobe width wrong");

    property p_rd_ready;
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(io_read_strobe_n_o) |-> !ready_n_o && recovery_hold_o;
    endproperty
    a_rd_ready: assert property (p_rd_ready) else $error("Read ready or recovery missing");

    property p_recovery_hold_len;
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(recovery_hold_o) |-> recovery_hold_o [*3] ##1 !recovery_hold_o;
    endproperty
    a_recovery_hold_len: assert property (p_recovery_hold_len) else $error("Recovery length wrong");

    property p_rd_held;
        @(posedge clk_i) disable iff (!rst_b_i)
        recovery_hold_o |=> !$fell(io_read_strobe_n_o);
    endproperty
    a_rd_held: assert property (p_rd_held) else $error("Read strobe not held off");

    property p_wr_delay;
        @(posedge clk_i) disable iff (!rst_b_i)
        ($fell(chip_select_n_o) && transceiver_direction_o) |-> ##[1:2] $fell(io_write_strobe_n_o);
    endproperty
    a_wr_delay: assert property (p_wr_delay) else $error("Write strobe delay wrong");

    property p_wr_data;
        @(posedge clk_i) disable iff (!rst_b_i)
        $rose(io_write_strobe_n_o) |-> io_wdata_oe_o && $stable(io_wdata_o);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("Write data unstable at strobe edge");

    property p_post_ready;
        @(posedge clk_i) disable iff (!rst_b_i)
        (io_start && s_q.st == ioc_pkg::IOC_IDLE && posted_mode_i && write_read_sel_i && !pw.full)
            |-> ##2 !ready_n_o;
    endproperty
    a_post_ready: assert property (p_post_ready) else $error("Posted write ready not in two clocks");

    property p_dir;
        @(posedge clk_i) disable iff (!rst_b_i)
        !io_read_strobe_n_o |-> !transceiver_direction_o;
    endproperty
    a_dir: assert property (p_dir) else $error("Direction high during read");

endmodule // ioc_cycle_ctrl

/* ioc_cpu_model.sv */
// Partner: processor local bus master that runs I/O read and write cycles
`timescale 1ns/1ps
module ioc_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        ready_n_i,
    output logic             address_strobe_n_o,
    output logic             mem_io_sel_o,
    output logic             write_read_sel_o,
    output logic             data_ctrl_sel_o,
    output logic [15:0]      addr_o,
    output logic [31:0]      wdata_o
);
    initial begin
        address_strobe_n_o = 1'b1;
        mem_io_sel_o       = 1'b1;
        write_read_sel_o   = 1'b0;
        data_ctrl_sel_o    = 1'b0;
        addr_o             = 16'h0000;
        wdata_o            = 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // Strobe with status in T1, data from T2, hold until ready sampled
    // ------------------------------------------------------------------
    task automatic bus_cycle(input logic wr, input logic mem, input logic [15:0] a,
                             input logic [31:0] d, input int max_clks);
        int n;
        n = 0;
        @(negedge clk_i);
        address_strobe_n_o = 1'b0;
        mem_io_sel_o       = mem;
        write_read_sel_o   = wr;
        data_ctrl_sel_o    = 1'b1;
        addr_o             = a;
        @(negedge clk_i);
        address_strobe_n_o = 1'b1;
        wdata_o            = wr ? d : ~wdata_o;
        do begin
            @(posedge clk_i);
            n++;
        end while (ready_n_i !== 1'b0 && n < max_clks);
    endtask

    // Released lines show the inverse of their last value
    task automatic release_bus();
        @(negedge clk_i);
        mem_io_sel_o     = ~mem_io_sel_o;
        write_read_sel_o = ~write_read_sel_o;
        data_ctrl_sel_o  = ~data_ctrl_sel_o;
        addr_o           = ~addr_o;
        wdata_o          = ~wdata_o;
    endtask
endmodule // ioc_cpu_model

/* io_cycle_control_logic_test.sv */
// Testbench: I/O cycle control logic against a processor bus model
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t mismatch got %0h expected %0h", $time, (got), (exp)); end end
module io_cycle_control_logic_test;
    localparam int FRD = 0, FCS = 1, FWR = 2, RDY = 3, NRD = 4, NWR = 5;
    localparam int NRDY = 6, NREC = 7, NPEND = 8, CLASH = 9, BAD = 10;
    localparam int RD_LEN = ioc_pkg::READ_WAIT_STATES + 1;
    localparam int WR_LEN = ioc_pkg::WRITE_WAIT_STATES + 1;
    localparam int REC = ioc_pkg::RECOVERY_CLKS;

    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        posted_mode_i = 1'b0;
    logic        address_strobe_n, mem_io_sel, write_read_sel, data_ctrl_sel;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        io_cycle_pending_o, io_read_strobe_n_o, io_write_strobe_n_o, chip_select_n_o;
    logic        recovery_hold_o, transceiver_direction_o, ready_n_o, io_wdata_oe_o;
    logic [15:0] io_addr_o;
    logic [31:0] io_wdata_o;
    logic        dir_rd, pend_rd, dir_wr;
    int          m [0:10];
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #5 clk_i = ~clk_i;

    ioc_cycle_ctrl DUT (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .address_strobe_n_i(address_strobe_n),
        .mem_io_sel_i(mem_io_sel), .write_read_sel_i(write_read_sel), .data_ctrl_sel_i(data_ctrl_sel),
        .addr_i(addr), .wdata_i(wdata), .posted_mode_i(posted_mode_i),
        .io_cycle_pending_o(io_cycle_pending_o), .io_read_strobe_n_o(io_read_strobe_n_o),
        .io_write_strobe_n_o(io_write_strobe_n_o), .chip_select_n_o(chip_select_n_o),
        .recovery_hold_o(recovery_hold_o), .transceiver_direction_o(transceiver_direction_o),
        .ready_n_o(ready_n_o), .io_addr_o(io_addr_o), .io_wdata_o(io_wdata_o),
        .io_wdata_oe_o(io_wdata_oe_o));

    ioc_cpu_model u_cpu (
        .clk_i(clk_i), .ready_n_i(ready_n_o), .address_strobe_n_o(address_strobe_n),
        .mem_io_sel_o(mem_io_sel), .write_read_sel_o(write_read_sel),
        .data_ctrl_sel_o(data_ctrl_sel), .addr_o(addr), .wdata_o(wdata));

    // ------------------------------------------------------------------
    // Observer: cycle k counts from the strobe cycle, sampled mid-cycle
    // ------------------------------------------------------------------
    task automatic observe(input int n, input logic [15:0] ea, input logic [31:0] ed);
        m = '{default: 0};
        @(negedge clk_i);
        for (int k = 1; k <= n; k++) begin
            @(negedge clk_i);
            if (io_read_strobe_n_o === 1'b0 && m[FRD] == 0) begin
                m[FRD] = k;
                dir_rd = transceiver_direction_o;
                pend_rd = io_cycle_pending_o;
            end
            if (io_write_strobe_n_o === 1'b0 && m[FWR] == 0) begin
                m[FWR] = k;
                dir_wr = transceiver_direction_o;
            end
            if (chip_select_n_o === 1'b0 && m[FCS] == 0) m[FCS] = k;
            if (ready_n_o === 1'b0 && m[RDY] == 0) m[RDY] = k;
            m[NRD] += (io_read_strobe_n_o === 1'b0);
            m[NWR] += (io_write_strobe_n_o === 1'b0);
            m[NRDY] += (ready_n_o === 1'b0);
            m[NREC] += (recovery_hold_o === 1'b1);
            m[NPEND] += (io_cycle_pending_o === 1'b1);
            m[CLASH] += (io_read_strobe_n_o === 1'b0 && recovery_hold_o === 1'b1);
            if (io_write_strobe_n_o === 1'b0 && (io_wdata_o !== ed || io_addr_o !== ea ||
                io_wdata_oe_o !== 1'b1 || chip_select_n_o !== 1'b0)) m[BAD]++;
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        repeat (5) @(negedge clk_i);
        `CHK(ready_n_o, 1'b1)
        `CHK(io_read_strobe_n_o & io_write_strobe_n_o, 1'b1)
        rst_b_i = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic t_read_plain();
        fork
            begin
                u_cpu.bus_cycle(1'b0, 1'b0, 16'h00e0, 32'h0, 20);
                u_cpu.release_bus();
            end
            observe(14, 16'h0, 32'h0);
        join
        `CHK(m[FRD], 2)
        `CHK(pend_rd, 1'b1)
        `CHK(dir_rd, 1'b0)
        `CHK(m[NRD], RD_LEN)
        `CHK(m[RDY], 2 + RD_LEN)
        `CHK(m[NRDY], 1)
        `CHK(m[NREC], REC)
        `CHK(io_cycle_pending_o, 1'b0)
    endtask

    task automatic t_read_b2b();
        fork
            begin
                u_cpu.bus_cycle(1'b0, 1'b0, 16'h00e4, 32'h0, 20);
                u_cpu.bus_cycle(1'b0, 1'b0, 16'h00e8, 32'h0, 20);
                u_cpu.release_bus();
            end
            observe(30, 16'h0, 32'h0);
        join
        `CHK(m[CLASH], 0)
        `CHK(m[NRD], 2 * RD_LEN)
        `CHK(m[NRDY], 2)
        `CHK(m[NREC], 2 * REC)
    endtask

    task automatic t_write_plain();
        fork
            begin
                u_cpu.bus_cycle(1'b1, 1'b0, 16'h00f0, 32'h5a3c_96e1, 20);
                u_cpu.release_bus();
            end
            observe(16, 16'h00f0, 32'h5a3c_96e1);
        join
        `CHK(m[FCS], 2)
        `CHK(m[FWR], 2 + ioc_pkg::WRITE_DELAY_CLKS)
        `CHK(dir_wr, 1'b1)
        `CHK(m[NWR], WR_LEN)
        `CHK(m[BAD], 0)
        `CHK(m[RDY], 2 + ioc_pkg::WRITE_DELAY_CLKS + WR_LEN)
        `CHK(m[NRD], 0)
        `CHK(m[NREC], REC)
    endtask

    task automatic t_posted();
        posted_mode_i = 1'b1;
        fork
            begin
                u_cpu.bus_cycle(1'b1, 1'b0, 16'h00fc, 32'hc3a5_0f81, 20);
                u_cpu.release_bus();
            end
            observe(20, 16'h00fc, 32'hc3a5_0f81);
        join
        posted_mode_i = 1'b0;
        `CHK(m[RDY], 2)
        `CHK(m[NRDY], 1)
        `CHK(m[FWR] > m[RDY], 1'b1)
        `CHK(m[NWR], WR_LEN)
        `CHK(m[BAD], 0)
    endtask

    task automatic t_not_io();
        fork
            begin
                u_cpu.bus_cycle(1'b0, 1'b1, 16'h00e0, 32'h0, 12);
                u_cpu.release_bus();
            end
            observe(14, 16'h0, 32'h0);
        join
        `CHK(m[NPEND], 0)
        `CHK(m[NRDY], 0)
        `CHK(m[FCS], 0)
    endtask

    initial begin
        t_reset();
        t_read_plain();
        repeat (4) @(negedge clk_i);
        t_read_b2b();
        repeat (4) @(negedge clk_i);
        t_write_plain();
        repeat (4) @(negedge clk_i);
        t_posted();
        repeat (4) @(negedge clk_i);
        t_not_io();
        close_out();
    end

    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
endmodule // io_cycle_control_logic_test
